// File: cidx_pkg.sv
// ----------------------------------------------------------------------------
// shared constants and types for the execution unit
// ----------------------------------------------------------------------------
package cidx_pkg;
    // register byte offsets on the avalon slave
    localparam logic [7:0] CIDX_OFS_CTRL = 8'h00; // w: start, r: busy / unknown
    localparam logic [7:0] CIDX_OFS_INSTR = 8'h04; // opcode, second, third byte
    localparam logic [7:0] CIDX_OFS_ACC = 8'h08; // accumulator
    localparam logic [7:0] CIDX_OFS_HREG = 8'h0c; // arithmetic helper register
    localparam logic [7:0] CIDX_OFS_PSW = 8'h10; // program_status_word
    localparam logic [7:0] CIDX_OFS_PC = 8'h14; // program counter
    localparam logic [7:0] CIDX_OFS_MEM = 8'h80; // internal data memory base
    // internal data memory, four banks of eight working registers
    localparam int CIDX_MEM_DEPTH = 32;
    localparam int CIDX_MEM_AW = 5;
    // program_status_word bit positions
    localparam int CIDX_PSW_CY = 7; // carry
    localparam int CIDX_PSW_HDC = 6; // half_digit_carry
    localparam int CIDX_PSW_BANK_HI = 4; // bank select, two bits
    localparam int CIDX_PSW_BANK_LO = 3;
    localparam int CIDX_PSW_OVF = 2; // overflow_flag
    localparam int CIDX_PSW_PAR = 0; // parity
    // control register bits
    localparam int CIDX_CTRL_START = 0;
    localparam int CIDX_CTRL_UNKNOWN = 1;
    // reset values
    localparam logic [7:0] CIDX_RST_BYTE = 8'h00;
    localparam logic [15:0] CIDX_RST_PC = 16'h0000;
    localparam logic [23:0] CIDX_RST_IR = 24'h000000;
    // decimal correction constants
    localparam logic [3:0] CIDX_DIGIT_MAX = 4'h9;
    localparam logic [8:0] CIDX_ADJ_LO = 9'h006;
    localparam logic [8:0] CIDX_ADJ_HI = 9'h060;
    // machine cycles per instruction class, minus one
    localparam logic [1:0] CIDX_CYC_ONE = 2'h0;
    localparam logic [1:0] CIDX_CYC_TWO = 2'h1;
    localparam logic [1:0] CIDX_CYC_DIV = 2'h3;

    // execution sequencer, gray coded
    typedef enum logic [1:0] {
        CIDX_ST_IDLE = 2'b00,
        CIDX_ST_EXEC = 2'b01
    } cidx_state_type;

    // decoded operation classes
    typedef enum logic [3:0] {
        CIDX_OP_UNKNOWN = 4'h0, CIDX_OP_FLIP_CARRY = 4'h1, CIDX_OP_FLIP_BIT = 4'h2,
        CIDX_OP_DECIMAL_ADJ = 4'h3, CIDX_OP_DECR_IND = 4'h4, CIDX_OP_DECR_ACC = 4'h5,
        CIDX_OP_DECR_REG = 4'h6, CIDX_OP_DECR_DIR = 4'h7, CIDX_OP_DIVIDE = 4'h8,
        CIDX_OP_LOOP_REG = 4'h9, CIDX_OP_LOOP_DIR = 4'ha, CIDX_OP_INCR_IND = 4'hb,
        CIDX_OP_INCR_ACC = 4'hc, CIDX_OP_INCR_REG = 4'hd, CIDX_OP_INCR_DIR = 4'he
    } cidx_op_type;

    // opcode byte to operation class
    function automatic cidx_op_type cidx_decode(input logic [7:0] opc);
        cidx_op_type r;
        r = CIDX_OP_UNKNOWN;
        if (opc == 8'hb3) r = CIDX_OP_FLIP_CARRY;
        else if (opc == 8'hb2) r = CIDX_OP_FLIP_BIT;
        else if (opc == 8'hd4) r = CIDX_OP_DECIMAL_ADJ;
        else if (opc[7:1] == 7'h0b) r = CIDX_OP_DECR_IND;
        else if (opc == 8'h14) r = CIDX_OP_DECR_ACC;
        else if (opc[7:3] == 5'h03) r = CIDX_OP_DECR_REG;
        else if (opc == 8'h15) r = CIDX_OP_DECR_DIR;
        else if (opc == 8'h84) r = CIDX_OP_DIVIDE;
        else if (opc[7:3] == 5'h1b) r = CIDX_OP_LOOP_REG;
        else if (opc == 8'hd5) r = CIDX_OP_LOOP_DIR;
        else if (opc[7:1] == 7'h03) r = CIDX_OP_INCR_IND;
        else if (opc == 8'h04) r = CIDX_OP_INCR_ACC;
        else if (opc[7:3] == 5'h01) r = CIDX_OP_INCR_REG;
        else if (opc == 8'h05) r = CIDX_OP_INCR_DIR;
        return r;
    endfunction : cidx_decode

    // instruction length in bytes
    function automatic logic [15:0] cidx_length(input cidx_op_type op);
        logic [15:0] n;
        n = 16'h0001;
        if (op == CIDX_OP_FLIP_BIT || op == CIDX_OP_DECR_DIR || op == CIDX_OP_INCR_DIR ||
            op == CIDX_OP_LOOP_REG) n = 16'h0002;
        else if (op == CIDX_OP_LOOP_DIR) n = 16'h0003;
        return n;
    endfunction : cidx_length
endpackage : cidx_pkg

// File: cidx_exec.sv
`timescale 1ns/10ps
// Summary of operation
// - carry complement inverts carry, other flags kept
// - bit complement inverts addressed bit, flags kept
// - low digit above nine or half carry: add six
// - high digit above nine or carry: add six, set carry
// - indirect step through register zero or one
// - accumulator decrement wraps, updates parity only
// - working register decrement wraps, flags kept
// - direct location decrement wraps, flags kept
// - divide takes four cycles, quotient and remainder
// - divide clears carry, overflow only on zero divisor
// - zero divisor leaves both operands unchanged
// - register loop decrements, branches when nonzero, two cycles
// - memory loop decrements, branches when nonzero, two cycles
// - accumulator increment wraps, updates parity only
module cidx_exec (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // avalon-mm slave
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // status
    output logic o_busy
);
    import cidx_pkg::*;

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    typedef struct packed {
        cidx_state_type state; // sequencer
        logic [1:0] cnt; // cycles left in the instruction after the current one
        logic [23:0] ir; // instruction bytes, opcode lowest
        logic [7:0] acc; // accumulator
        logic [7:0] hreg; // helper register
        logic [7:0] program_status_word; // program_status_word
        logic [15:0] pc; // program counter
        logic [CIDX_MEM_DEPTH-1:0][7:0] mem; // data memory, banks at the bottom
        logic unknown; // set when the last retired opcode was not handled here, cleared by the next retire
        logic wait_q; // registered waitrequest
        logic [31:0] rdata; // registered read data
    } cidx_regs_type;

    cidx_regs_type r_q; // registered copy
    cidx_regs_type r_d; // next value

    // byte-lane merge for partial writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) m[i*8 +: 8] = nw[i*8 +: 8];
        end
        return m;
    endfunction : lane_merge

    // ------------------------------------------------------------------------
    // decode helpers, shared with the checks below
    // ------------------------------------------------------------------------
    cidx_op_type ex_op; // class of the held instruction
    logic retire; // last cycle of the instruction
    logic [CIDX_MEM_AW-1:0] reg_idx; // working register in the active bank
    logic [CIDX_MEM_AW-1:0] ind_idx; // location pointed to by register 0 or 1
    logic [CIDX_MEM_AW-1:0] dir_idx; // location named by the second byte
    logic [CIDX_MEM_AW-1:0] tgt_idx; // memory operand of the step ops
    logic [7:0] tgt_val; // memory operand value
    logic [7:0] step_val; // memory operand after the step
    logic [15:0] pc_adv; // counter past the whole instruction
    logic [15:0] pc_rel; // branch target
    logic bus_req; // access presented this cycle

    always_comb begin
        ex_op = cidx_decode(r_q.ir[7:0]);
        retire = (r_q.state == CIDX_ST_EXEC) && (r_q.cnt == CIDX_CYC_ONE);
        reg_idx = {r_q.program_status_word[CIDX_PSW_BANK_HI:CIDX_PSW_BANK_LO], r_q.ir[2:0]};
        // pointer registers live in the active bank; memory is only 32 deep
        ind_idx = r_q.mem[{r_q.program_status_word[CIDX_PSW_BANK_HI:CIDX_PSW_BANK_LO], 2'b00, r_q.ir[0]}][CIDX_MEM_AW-1:0];
        dir_idx = r_q.ir[8 +: CIDX_MEM_AW];
        // pick the memory operand
        case (ex_op)
            CIDX_OP_DECR_IND, CIDX_OP_INCR_IND: tgt_idx = ind_idx;
            CIDX_OP_DECR_REG, CIDX_OP_INCR_REG, CIDX_OP_LOOP_REG: tgt_idx = reg_idx;
            default: tgt_idx = dir_idx;
        endcase
        tgt_val = r_q.mem[tgt_idx];
        // increments add one, everything else here subtracts one, wrapping
        if (ex_op == CIDX_OP_INCR_IND || ex_op == CIDX_OP_INCR_REG || ex_op == CIDX_OP_INCR_DIR) begin
            step_val = tgt_val + 8'h01;
        end else begin
            step_val = tgt_val - 8'h01;
        end
        pc_adv = r_q.pc + cidx_length(ex_op);
        // offset sign-extended and applied after the counter advanced
        if (ex_op == CIDX_OP_LOOP_REG) begin
            pc_rel = pc_adv + {{8{r_q.ir[15]}}, r_q.ir[15:8]};
        end else begin
            pc_rel = pc_adv + {{8{r_q.ir[23]}}, r_q.ir[23:16]};
        end
        bus_req = i_read || i_write;
    end

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        logic [8:0] da_sum; // decimal correction working sum
        logic da_cy; // carry into the high digit test
        logic [31:0] wr; // merged write word
        logic [31:0] rd; // read mux
        da_sum = 9'h000;
        da_cy = 1'b0;
        wr = 32'h00000000;
        rd = 32'h00000000;
        r_d = r_q;

        // sequencer
        case (r_q.state)
            CIDX_ST_IDLE: begin
                r_d.cnt = CIDX_CYC_ONE;
            end
            CIDX_ST_EXEC: begin
                if (r_q.cnt != CIDX_CYC_ONE) begin
                    r_d.cnt = r_q.cnt - 2'h1;
                end else begin
                    r_d.state = CIDX_ST_IDLE;
                end
            end
            default: begin
                r_d.state = CIDX_ST_IDLE;
            end
        endcase

        // effects all land in the final cycle so a long op looks atomic
        if (retire) begin
            r_d.pc = pc_adv;
            r_d.unknown = 1'b0;
            case (ex_op)
                CIDX_OP_FLIP_CARRY: begin
                    r_d.program_status_word[CIDX_PSW_CY] = ~r_q.program_status_word[CIDX_PSW_CY];
                end
                CIDX_OP_FLIP_BIT: begin
                    // bit address: upper five bits pick the byte, low three the bit
                    r_d.mem[r_q.ir[15:11]][r_q.ir[10:8]] = ~r_q.mem[r_q.ir[15:11]][r_q.ir[10:8]];
                end
                CIDX_OP_DECIMAL_ADJ: begin
                    da_sum = {1'b0, r_q.acc};
                    if (r_q.acc[3:0] > CIDX_DIGIT_MAX || r_q.program_status_word[CIDX_PSW_HDC]) begin
                        da_sum = da_sum + CIDX_ADJ_LO;
                    end
                    // a carry out of the low correction counts toward the high digit
                    da_cy = da_sum[8] || r_q.program_status_word[CIDX_PSW_CY];
                    if (da_sum[7:4] > CIDX_DIGIT_MAX || da_cy) begin
                        da_sum = {1'b0, da_sum[7:0]} + CIDX_ADJ_HI;
                        r_d.program_status_word[CIDX_PSW_CY] = 1'b1;
                    end
                    r_d.acc = da_sum[7:0];
                    r_d.program_status_word[CIDX_PSW_PAR] = ^da_sum[7:0];
                end
                CIDX_OP_DECR_ACC: begin
                    r_d.acc = r_q.acc - 8'h01;
                    r_d.program_status_word[CIDX_PSW_PAR] = ^r_d.acc;
                end
                CIDX_OP_INCR_ACC: begin
                    r_d.acc = r_q.acc + 8'h01;
                    r_d.program_status_word[CIDX_PSW_PAR] = ^r_d.acc;
                end
                CIDX_OP_DECR_IND, CIDX_OP_INCR_IND, CIDX_OP_DECR_REG, CIDX_OP_INCR_REG,
                CIDX_OP_DECR_DIR, CIDX_OP_INCR_DIR: begin
                    r_d.mem[tgt_idx] = step_val;
                end
                CIDX_OP_LOOP_REG, CIDX_OP_LOOP_DIR: begin
                    r_d.mem[tgt_idx] = step_val;
                    if (step_val != 8'h00) r_d.pc = pc_rel;
                end
                CIDX_OP_DIVIDE: begin
                    r_d.program_status_word[CIDX_PSW_CY] = 1'b0;
                    if (r_q.hreg == 8'h00) begin
                        r_d.program_status_word[CIDX_PSW_OVF] = 1'b1;
                    end else begin
                        r_d.program_status_word[CIDX_PSW_OVF] = 1'b0;
                        r_d.acc = r_q.acc / r_q.hreg;
                        r_d.hreg = r_q.acc % r_q.hreg;
                        r_d.program_status_word[CIDX_PSW_PAR] = ^(r_q.acc / r_q.hreg);
                    end
                end
                default: begin
                    // not handled here: skip one byte, flag it
                    r_d.unknown = 1'b1;
                end
            endcase
        end

        // bus slave: one wait cycle, then the answer for one edge
        if (bus_req && r_q.wait_q) begin
            r_d.wait_q = 1'b0;
            case (i_address)
                CIDX_OFS_CTRL: begin
                    rd[CIDX_CTRL_START] = (r_q.state != CIDX_ST_IDLE);
                    rd[CIDX_CTRL_UNKNOWN] = r_q.unknown;
                end
                CIDX_OFS_INSTR: rd[23:0] = r_q.ir;
                CIDX_OFS_ACC: rd[7:0] = r_q.acc;
                CIDX_OFS_HREG: rd[7:0] = r_q.hreg;
                CIDX_OFS_PSW: rd[7:0] = r_q.program_status_word;
                CIDX_OFS_PC: rd[15:0] = r_q.pc;
                default: begin
                    // memory window, everything else reads zero
                    if (i_address >= CIDX_OFS_MEM && i_address[1:0] == 2'b00) begin
                        rd[7:0] = r_q.mem[i_address[2 +: CIDX_MEM_AW]];
                    end
                end
            endcase
            r_d.rdata = rd;
        end else begin
            r_d.wait_q = 1'b1;
        end

        // writes take effect on the completing edge; dropped while executing
        if (i_write && !r_q.wait_q && r_q.state == CIDX_ST_IDLE) begin
            wr = i_writedata;
            case (i_address)
                CIDX_OFS_CTRL: begin
                    if (i_byteenable[0] && wr[CIDX_CTRL_START]) begin
                        r_d.state = CIDX_ST_EXEC;
                        case (cidx_decode(r_q.ir[7:0]))
                            CIDX_OP_DIVIDE: r_d.cnt = CIDX_CYC_DIV;
                            CIDX_OP_LOOP_REG, CIDX_OP_LOOP_DIR: r_d.cnt = CIDX_CYC_TWO;
                            default: r_d.cnt = CIDX_CYC_ONE;
                        endcase
                    end
                end
                CIDX_OFS_INSTR: begin
                    wr = lane_merge({8'h00, r_q.ir}, i_writedata, i_byteenable);
                    r_d.ir = wr[23:0];
                end
                CIDX_OFS_ACC: if (i_byteenable[0]) r_d.acc = wr[7:0];
                CIDX_OFS_HREG: if (i_byteenable[0]) r_d.hreg = wr[7:0];
                CIDX_OFS_PSW: if (i_byteenable[0]) r_d.program_status_word = wr[7:0];
                CIDX_OFS_PC: begin
                    wr = lane_merge({16'h0000, r_q.pc}, i_writedata, i_byteenable);
                    r_d.pc = wr[15:0];
                end
                default: begin
                    if (i_address >= CIDX_OFS_MEM && i_address[1:0] == 2'b00 && i_byteenable[0]) begin
                        r_d.mem[i_address[2 +: CIDX_MEM_AW]] = wr[7:0];
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            r_q.state <= CIDX_ST_IDLE;
            r_q.cnt <= CIDX_CYC_ONE;
            r_q.ir <= CIDX_RST_IR;
            r_q.acc <= CIDX_RST_BYTE;
            r_q.hreg <= CIDX_RST_BYTE;
            r_q.program_status_word <= CIDX_RST_BYTE;
            r_q.pc <= CIDX_RST_PC;
            r_q.mem <= '0;
            r_q.unknown <= 1'b0;
            r_q.wait_q <= 1'b1;
            r_q.rdata <= 32'h00000000;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs straight from flops
    assign o_readdata = r_q.rdata;
    assign o_waitrequest = r_q.wait_q;
    // exec is the only state with bit 0 set, so busy is a plain flop bit
    assign o_busy = r_q.state[0];

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    // divide enters execution with three more cycles to go
    sequence s_div_issue;
        r_q.state == CIDX_ST_IDLE ##1 (r_q.state == CIDX_ST_EXEC && ex_op == CIDX_OP_DIVIDE);
    endsequence
    // loop op enters execution
    sequence s_loop_issue;
        r_q.state == CIDX_ST_IDLE ##1 (r_q.state == CIDX_ST_EXEC &&
            (ex_op == CIDX_OP_LOOP_REG || ex_op == CIDX_OP_LOOP_DIR));
    endsequence

    a_flip_carry_only: assert property (retire && ex_op == CIDX_OP_FLIP_CARRY |=>
        r_q.program_status_word == ($past(r_q.program_status_word) ^ 8'h80))
        else $error("carry complement wrong");
    a_flip_bit_flags: assert property (retire && ex_op == CIDX_OP_FLIP_BIT |=>
        r_q.program_status_word == $past(r_q.program_status_word) && r_q.mem != $past(r_q.mem))
        else $error("bit complement wrong");
    a_decimal_keep: assert property (retire && ex_op == CIDX_OP_DECIMAL_ADJ && r_q.acc[3:0] < 4'ha &&
        r_q.acc[7:4] < 4'ha && r_q.program_status_word[7:6] == 2'b00 |=> r_q.acc == $past(r_q.acc) && !r_q.program_status_word[7])
        else $error("decimal adjust changed a valid value");
    a_decimal_carry: assert property (retire && ex_op == CIDX_OP_DECIMAL_ADJ && r_q.program_status_word[7] |=>
        r_q.program_status_word[7] && r_q.acc == $past(r_q.acc) + 8'h60 + ($past(r_q.acc[3:0]) > 4'h9 ? 8'h06 : 8'h00) +
        ($past(r_q.acc[3:0]) <= 4'h9 && $past(r_q.program_status_word[6]) ? 8'h06 : 8'h00))
        else $error("decimal adjust high digit wrong");
    a_ind_step: assert property (retire && ex_op == CIDX_OP_INCR_IND |=>
        r_q.mem[$past(ind_idx)] == $past(tgt_val) + 8'h01 && r_q.program_status_word == $past(r_q.program_status_word))
        else $error("indirect increment wrong");
    a_acc_decr: assert property (retire && ex_op == CIDX_OP_DECR_ACC |=>
        r_q.acc == $past(r_q.acc) - 8'h01 && r_q.program_status_word[0] == ^r_q.acc && r_q.program_status_word[7:1] == $past(r_q.program_status_word[7:1]))
        else $error("accumulator decrement wrong");
    a_reg_decr: assert property (retire && ex_op == CIDX_OP_DECR_REG |=>
        r_q.mem[$past(reg_idx)] == $past(tgt_val) - 8'h01 && r_q.program_status_word == $past(r_q.program_status_word))
        else $error("register decrement wrong");
    a_dir_decr: assert property (retire && ex_op == CIDX_OP_DECR_DIR |=>
        r_q.mem[$past(dir_idx)] == $past(tgt_val) - 8'h01 && r_q.pc == $past(r_q.pc) + 16'h0002)
        else $error("direct decrement wrong");
    a_div_four: assert property (s_div_issue |-> !retire [*3] ##1 retire)
        else $error("divide not four cycles");
    a_div_flags: assert property (retire && ex_op == CIDX_OP_DIVIDE |=>
        !r_q.program_status_word[7] && r_q.program_status_word[2] == ($past(r_q.hreg) == 8'h00))
        else $error("divide flags wrong");
    a_div_zero_keep: assert property (retire && ex_op == CIDX_OP_DIVIDE && r_q.hreg == 8'h00 |=>
        r_q.acc == $past(r_q.acc) && r_q.hreg == 8'h00)
        else $error("divide by zero changed operands");
    a_loop_fall: assert property (retire && ex_op == CIDX_OP_LOOP_REG && tgt_val == 8'h01 |=>
        r_q.pc == $past(r_q.pc) + 16'h0002)
        else $error("register loop did not fall through");
    a_loop_two: assert property (s_loop_issue |-> ##1 retire)
        else $error("loop not two cycles");
    a_acc_incr: assert property (retire && ex_op == CIDX_OP_INCR_ACC |=>
        r_q.acc == $past(r_q.acc) + 8'h01 && r_q.program_status_word[7:1] == $past(r_q.program_status_word[7:1]))
        else $error("accumulator increment wrong");
    a_loop_back: assert property (retire && ex_op == CIDX_OP_LOOP_DIR && tgt_val == 8'h05 &&
        r_q.ir[23:16] == 8'hfd |=> r_q.pc == $past(r_q.pc))
        else $error("backward branch target wrong");
endmodule : cidx_exec

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
    import cidx_pkg::*;
    // ------------------------------------------------------------
    // signals, counters and case table
    // ------------------------------------------------------------
    logic i_sys_clk = 1'b0, i_rst = 1'b1, i_read = 1'b0, i_write = 1'b0; // bus idle at time zero
    logic [7:0] i_address = 8'h00;
    logic [31:0] i_writedata = 32'h0, o_readdata, rd_v;
    logic [3:0] i_byteenable = 4'hf; // all lanes, memory needs lane 0
    logic o_waitrequest, o_busy;
    int bad_count = 0, n_checks = 0, nb;
    typedef struct {logic [23:0] ins; logic [7:0] a, b, p, mi, mv, ea, eb, ep, me; logic [15:0] pc; int n;} cidx_row_type;
    cidx_row_type t[22];
    cidx_exec cidx_exec_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_busy(o_busy));
    // free running clock, 100 ns period
    initial begin
        forever #50 i_sys_clk = ~i_sys_clk;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // one edge of gap first, so a released strobe is never raised in the same step
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge i_sys_clk);
        i_address <= a;
        i_writedata <= d;
        i_write <= w;
        i_read <= !w;
        k = 0;
        do begin
            @(posedge i_sys_clk);
            k++;
        end while (o_waitrequest !== 1'b0 && k < 50);
        rd_v = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
        if (k >= 50) begin
            bad_count++;
            wrap_up();
        end
    endtask : bus
    // load, start, then count edges with busy seen high
    task automatic run(input logic [23:0] ins);
        bus(1'b1, CIDX_OFS_INSTR, {8'h00, ins});
        bus(1'b1, CIDX_OFS_CTRL, 32'h1);
        nb = 0;
        forever begin
            @(posedge i_sys_clk);
            if (o_busy !== 1'b1 || nb > 20) break;
            nb++;
        end
        if (nb > 20) begin
            bad_count++;
            wrap_up();
        end
    endtask : run
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        t[0] = '{24'h0000b3, 8'h00, 8'h00, 8'h00, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 16'h0101, 1};
        t[1] = '{24'h001fb2, 8'h00, 8'h00, 8'h84, 8'h03, 8'hd7, 8'h00, 8'h00, 8'h84, 8'h57, 16'h0102, 1};
        t[2] = '{24'h0000d4, 8'h9a, 8'h00, 8'h00, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 16'h0101, 1};
        t[3] = '{24'h0000d4, 8'h3a, 8'h00, 8'h80, 8'h1f, 8'h00, 8'ha0, 8'h00, 8'h80, 8'h00, 16'h0101, 1};
        t[4] = '{24'h0000d4, 8'h9f, 8'h00, 8'h00, 8'h1f, 8'h00, 8'h05, 8'h00, 8'h80, 8'h00, 16'h0101, 1};
        t[5] = '{24'h0000d4, 8'h81, 8'h00, 8'h40, 8'h1f, 8'h00, 8'h87, 8'h00, 8'h40, 8'h00, 16'h0101, 1};
        t[6] = '{24'h000017, 8'h00, 8'h00, 8'h00, 8'h14, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 16'h0101, 1};
        t[7] = '{24'h000006, 8'h00, 8'h00, 8'h00, 8'h15, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h80, 16'h0101, 1};
        t[8] = '{24'h000014, 8'h00, 8'h00, 8'hc4, 8'h1f, 8'h00, 8'hff, 8'h00, 8'hc4, 8'h00, 16'h0101, 1};
        t[9] = '{24'h000004, 8'hff, 8'h00, 8'h84, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h84, 8'h00, 16'h0101, 1};
        t[10] = '{24'h00001f, 8'h00, 8'h00, 8'h08, 8'h0f, 8'h80, 8'h00, 8'h00, 8'h08, 8'h7f, 16'h0101, 1};
        t[11] = '{24'h001a15, 8'h00, 8'h00, 8'h00, 8'h1a, 8'hff, 8'h00, 8'h00, 8'h00, 8'hfe, 16'h0102, 1};
        t[12] = '{24'h000084, 8'hae, 8'h07, 8'h84, 8'h1f, 8'h00, 8'h18, 8'h06, 8'h00, 8'h00, 16'h0101, 4};
        t[13] = '{24'h000084, 8'h55, 8'h00, 8'h80, 8'h1f, 8'h00, 8'h55, 8'h00, 8'h04, 8'h00, 16'h0101, 4};
        t[14] = '{24'h00feda, 8'h00, 8'h00, 8'h00, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0102, 2};
        t[15] = '{24'h00feda, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 16'h0100, 2};
        t[16] = '{24'h7f09d5, 8'h00, 8'h00, 8'h00, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 16'h0182, 2};
        t[17] = '{24'h8009d5, 8'h00, 8'h00, 8'h00, 8'h09, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0103, 2};
        t[18] = '{24'h0000d4, 8'h45, 8'h00, 8'h00, 8'h1f, 8'h00, 8'h45, 8'h00, 8'h01, 8'h00, 16'h0101, 1};
        t[19] = '{24'hfd09d5, 8'h00, 8'h00, 8'h00, 8'h09, 8'h05, 8'h00, 8'h00, 8'h00, 8'h04, 16'h0100, 2};
        // register and direct increments, decoded beside the decrements
        t[20] = '{24'h00000d, 8'h00, 8'h00, 8'h00, 8'h05, 8'hbf, 8'h00, 8'h00, 8'h00, 8'hc0, 16'h0101, 1};
        t[21] = '{24'h001005, 8'h00, 8'h00, 8'h00, 8'h10, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0102, 1};
        repeat (3) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        // pointers for the indirect cases: r0 -> 0x15, r1 -> 0x14
        bus(1'b1, 8'h80, 32'h15);
        bus(1'b1, 8'h84, 32'h14);
        foreach (t[r]) begin
            bus(1'b1, CIDX_OFS_ACC, {24'h0, t[r].a});
            bus(1'b1, CIDX_OFS_HREG, {24'h0, t[r].b});
            bus(1'b1, CIDX_OFS_PSW, {24'h0, t[r].p});
            bus(1'b1, CIDX_OFS_PC, 32'h0100);
            bus(1'b1, {1'b1, t[r].mi[4:0], 2'b00}, {24'h0, t[r].mv});
            run(t[r].ins);
            chk("cycles", t[r].n, nb);
            bus(1'b0, CIDX_OFS_ACC, 32'h0);
            chk("acc", {24'h0, t[r].ea}, rd_v);
            bus(1'b0, CIDX_OFS_HREG, 32'h0);
            chk("hreg", {24'h0, t[r].eb}, rd_v);
            bus(1'b0, CIDX_OFS_PSW, 32'h0);
            chk("psw", {24'h0, t[r].ep}, rd_v);
            bus(1'b0, {1'b1, t[r].mi[4:0], 2'b00}, 32'h0);
            chk("mem", {24'h0, t[r].me}, rd_v);
            bus(1'b0, CIDX_OFS_PC, 32'h0);
            chk("pc", {16'h0, t[r].pc}, rd_v);
            $display("case %0d done", r);
        end
        // second reset in mid-run, then an unknown opcode and an unmapped read
        @(posedge i_sys_clk);
        i_rst <= 1'b1;
        @(posedge i_sys_clk);
        chk("wait_in_reset", 32'h1, {31'h0, o_waitrequest});
        i_rst <= 1'b0;
        bus(1'b0, CIDX_OFS_ACC, 32'h0);
        chk("acc_reset", 32'h0, rd_v);
        run(24'h0000a5);
        bus(1'b0, CIDX_OFS_CTRL, 32'h0);
        chk("ctrl_unknown", 32'h2, rd_v);
        bus(1'b0, CIDX_OFS_PC, 32'h0);
        chk("pc_unknown", 32'h1, rd_v);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd_v);
        // partial write: only lane 0 of the counter may change
        i_byteenable <= 4'h1;
        bus(1'b1, CIDX_OFS_PC, 32'h0000ab12);
        i_byteenable <= 4'hf;
        bus(1'b0, CIDX_OFS_PC, 32'h0);
        chk("pc_lane0", 32'h12, rd_v);
        $display("hand tests done");
        wrap_up();
    end
endmodule : testbench
